/* File: hw/ext_irq_pkg.sv */
// Constants, register map and sense encodings for the external pin interrupt block.
// Assumes an 8-bit data-space register port driven from the CPU clock domain.
package ext_irq_pkg;
   // Data-space register offsets
   localparam logic [7:0] ADDR_CHANGE_FLAGS = 8'h3b;
   localparam logic [7:0] ADDR_EXT_FLAGS = 8'h3c;
   localparam logic [7:0] ADDR_EXT_MASK = 8'h3d;
   localparam logic [7:0] ADDR_GROUP_CTRL = 8'h68;
   localparam logic [7:0] ADDR_SENSE_CTRL = 8'h69;
   localparam logic [7:0] ADDR_MASK_ZERO = 8'h6b;
   localparam logic [7:0] ADDR_MASK_ONE = 8'h6c;
   localparam logic [7:0] ADDR_MASK_TWO = 8'h6d;
   // Address that decodes to nothing
   localparam logic [7:0] ADDR_NONE = 8'h00;
   // I/O space window: I/O address plus offset gives data-space address
   localparam logic [7:0] IO_OFFSET = 8'h20;
   localparam logic [7:0] IO_TOP = 8'h3f;
   // Reset value of every register
   localparam logic [7:0] REG_RESET = 8'h00;
   // Field widths and positions
   localparam int EXT_PINS = 2;
   localparam int SENSE_W = 2;
   localparam int GROUPS = 3;
   localparam int CHANGE_PINS = 24;
   localparam int GROUP_ZERO_LSB = 0;
   localparam int GROUP_ZERO_W = 8;
   localparam int GROUP_ONE_LSB = 8;
   localparam int GROUP_ONE_W = 7;
   localparam int GROUP_TWO_LSB = 16;
   localparam int GROUP_TWO_W = 8;
   localparam int SYNC_STAGES = 2;
   // Sense control encodings
   typedef enum logic [1:0] {
      SENSE_LOW = 2'b00,
      SENSE_ANY = 2'b01,
      SENSE_FALL = 2'b10,
      SENSE_RISE = 2'b11
   } sense_t;
endpackage

/* File: hw/external_pin_interrupts.sv */
// External pin and pin-change interrupt controller with its register file.
// Assumes a CPU register port on clk, an interrupt flag from the CPU status word,
// and one vector-entry acknowledge pulse per vector from the CPU.
`timescale 1ns/1ps
//
// Notes on behaviour
// [RL1] Pin one sense: low, change, fall, rise
// [RL2] Pin zero sense in bits 1:0, same codes
// [RL3] Sample pin first; pulses over one clock trigger
// [RL4] Driver holds low level until instruction ends
// [RL5] Low level requests continuously while pin low
// [RL6] Edges need clock; low level wakes asynchronously
// [RL7] Pin change wakes asynchronously without clock
// [RL8] Groups 23:16, 14:8, 7:0 with per-pin masks
// [RL9] Pins driven as outputs still trigger
// [RL10] Enable bit and global flag gate requests
// [RL11] Each source has its own vector request
// [RL12] Pin one flag set on triggering edge
// [RL13] Flag clears on vector entry or write one
// [RL14] Flag reads zero in low-level mode
// [RL15] Registers below 0x60 also reachable at offset minus 0x20
// [RL16] Vanished level wakes but raises no interrupt
// [RL17] Pin zero flag set, cleared like pin one
// [RL18] Group control enables groups two, one, zero
// [RL19] Group flag set on change, write-one clears
// [RL20] Per-pin mask registers, reset to zero
// [RL21] Synchronise pins; separate asynchronous wake paths
module external_pin_interrupts (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic extPinZero,
   input wire logic extPinOne,
   input wire logic [ext_irq_pkg::CHANGE_PINS-1:0] pinChangeInputs,
   input wire logic globalIntEnable,
   input wire logic [7:0] regAddr,
   input wire logic ioSpace,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   input wire logic ackPinZero,
   input wire logic ackPinOne,
   input wire logic [ext_irq_pkg::GROUPS-1:0] ackGroup,
   output logic reqPinZero,
   output logic reqPinOne,
   output logic [ext_irq_pkg::GROUPS-1:0] reqGroup,
   output logic wakeLevel,
   output logic wakeChange
);
   import ext_irq_pkg::*;

   typedef struct packed {
      logic [SENSE_W*EXT_PINS-1:0] senseCtrl;
      logic [EXT_PINS-1:0] extIrqEnableMask;
      logic [EXT_PINS-1:0] extIrqFlags;
      logic [GROUPS-1:0] changeGroupCtrl;
      logic [GROUPS-1:0] changeGroupFlags;
      logic [GROUP_ZERO_W-1:0] changeMaskGroupZero;
      logic [GROUP_ONE_W-1:0] changeMaskGroupOne;
      logic [GROUP_TWO_W-1:0] changeMaskGroupTwo;
      logic [EXT_PINS-1:0] extPrev;
      logic [CHANGE_PINS-1:0] changePrev;
      logic [7:0] rdData;
   } irq_state_t;

   irq_state_t state_reg;
   irq_state_t state_next;

   logic [EXT_PINS-1:0] extRaw;
   logic [EXT_PINS-1:0] extSync;
   logic [CHANGE_PINS-1:0] changeSync;
   logic [CHANGE_PINS-1:0] changeMask;
   logic [EXT_PINS-1:0] extAck;
   logic [EXT_PINS-1:0] levelMode;
   logic [EXT_PINS-1:0] extReq;
   logic [7:0] effAddr;
   logic [7:0] flagsView;

   assign extRaw = {extPinOne, extPinZero};
   assign extAck = {ackPinOne, ackPinZero};

   // Pins are synchronised before edge comparison; driven outputs loop back here too
   pin_sync #(.WIDTH(EXT_PINS)) extSyncInst ( // see [RL3] [RL9] [RL21]
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .pinIn(extRaw),
      .pinOut(extSync)
   );

   pin_sync #(.WIDTH(CHANGE_PINS)) changeSyncInst ( // see [RL21]
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .pinIn(pinChangeInputs),
      .pinOut(changeSync)
   );

   // Combined per-pin mask, bit 15 has no mask and never contributes
   always_comb begin
      changeMask = '0;
      changeMask[GROUP_ZERO_LSB +: GROUP_ZERO_W] = state_reg.changeMaskGroupZero; // see [RL8]
      changeMask[GROUP_ONE_LSB +: GROUP_ONE_W] = state_reg.changeMaskGroupOne;
      changeMask[GROUP_TWO_LSB +: GROUP_TWO_W] = state_reg.changeMaskGroupTwo;
   end

   // I/O space addresses map into data space by adding the window offset
   always_comb begin
      if (!ioSpace) begin
         effAddr = regAddr;
      end else if (regAddr <= IO_TOP) begin
         effAddr = 8'(regAddr + IO_OFFSET); // see [RL15]
      end else begin
         effAddr = ADDR_NONE;
      end
   end

   // Low-level mode per pin
   always_comb begin
      for (int i = 0; i < EXT_PINS; i++) begin
         levelMode[i] = sense_t'(state_reg.senseCtrl[i*SENSE_W +: SENSE_W]) == SENSE_LOW;
      end
   end

   assign flagsView = {{(8-EXT_PINS){1'b0}}, state_reg.extIrqFlags & ~levelMode}; // see [RL14]

   always_comb begin
      logic [EXT_PINS-1:0] rise;
      logic [EXT_PINS-1:0] fall;
      logic [EXT_PINS-1:0] hit;
      logic [EXT_PINS-1:0] extClr;
      logic [CHANGE_PINS-1:0] toggled;
      logic [GROUPS-1:0] groupHit;
      logic [GROUPS-1:0] groupClr;
      sense_t mode;
      rise = '0;
      fall = '0;
      hit = '0;
      extClr = '0;
      toggled = '0;
      groupHit = '0;
      groupClr = '0;
      mode = SENSE_LOW;
      state_next = state_reg;
      if (ce) begin
         state_next.extPrev = extSync;
         state_next.changePrev = changeSync;

         // Edge detection on the synchronised pins
         rise = extSync & ~state_reg.extPrev; // see [RL3] [RL6]
         fall = ~extSync & state_reg.extPrev;
         extClr = extAck; // see [RL13]
         if (regWrite && effAddr == ADDR_EXT_FLAGS) begin
            extClr = extClr | regWrData[EXT_PINS-1:0]; // see [RL13]
         end
         for (int i = 0; i < EXT_PINS; i++) begin
            mode = sense_t'(state_reg.senseCtrl[i*SENSE_W +: SENSE_W]); // see [RL1] [RL2]
            unique case (mode)
               SENSE_LOW: hit[i] = 1'b0;
               SENSE_ANY: hit[i] = rise[i] | fall[i];
               SENSE_FALL: hit[i] = fall[i];
               SENSE_RISE: hit[i] = rise[i];
            endcase
            if (mode == SENSE_LOW) begin
               state_next.extIrqFlags[i] = 1'b0; // see [RL14]
            end else if (hit[i]) begin
               state_next.extIrqFlags[i] = 1'b1; // see [RL12] [RL17]
            end else if (extClr[i]) begin
               state_next.extIrqFlags[i] = 1'b0; // see [RL13] [RL17]
            end
         end

         // Grouped pin change detection
         toggled = (changeSync ^ state_reg.changePrev) & changeMask; // see [RL8]
         groupHit[0] = |toggled[GROUP_ZERO_LSB +: GROUP_ZERO_W];
         groupHit[1] = |toggled[GROUP_ONE_LSB +: GROUP_ONE_W];
         groupHit[2] = |toggled[GROUP_TWO_LSB +: GROUP_TWO_W];
         groupClr = ackGroup; // see [RL19]
         if (regWrite && effAddr == ADDR_CHANGE_FLAGS) begin
            groupClr = groupClr | regWrData[GROUPS-1:0]; // see [RL19]
         end
         for (int g = 0; g < GROUPS; g++) begin
            if (groupHit[g]) begin
               state_next.changeGroupFlags[g] = 1'b1; // see [RL19]
            end else if (groupClr[g]) begin
               state_next.changeGroupFlags[g] = 1'b0;
            end
         end

         // Register writes
         if (regWrite) begin
            unique case (effAddr)
               ADDR_EXT_MASK: state_next.extIrqEnableMask = regWrData[EXT_PINS-1:0];
               ADDR_SENSE_CTRL: state_next.senseCtrl = regWrData[SENSE_W*EXT_PINS-1:0];
               ADDR_GROUP_CTRL: state_next.changeGroupCtrl = regWrData[GROUPS-1:0]; // see [RL18]
               ADDR_MASK_ZERO: state_next.changeMaskGroupZero = regWrData[GROUP_ZERO_W-1:0];
               ADDR_MASK_ONE: state_next.changeMaskGroupOne = regWrData[GROUP_ONE_W-1:0];
               ADDR_MASK_TWO: state_next.changeMaskGroupTwo = regWrData[GROUP_TWO_W-1:0];
               default: begin
               end
            endcase
         end

         // Register reads, unmapped addresses return zero
         if (regRead) begin
            unique case (effAddr)
               ADDR_EXT_FLAGS: state_next.rdData = flagsView; // see [RL14]
               ADDR_EXT_MASK: state_next.rdData = 8'(state_reg.extIrqEnableMask);
               ADDR_SENSE_CTRL: state_next.rdData = 8'(state_reg.senseCtrl);
               ADDR_CHANGE_FLAGS: state_next.rdData = 8'(state_reg.changeGroupFlags);
               ADDR_GROUP_CTRL: state_next.rdData = 8'(state_reg.changeGroupCtrl);
               ADDR_MASK_ZERO: state_next.rdData = 8'(state_reg.changeMaskGroupZero);
               ADDR_MASK_ONE: state_next.rdData = 8'(state_reg.changeMaskGroupOne);
               ADDR_MASK_TWO: state_next.rdData = 8'(state_reg.changeMaskGroupTwo);
               default: state_next.rdData = REG_RESET;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= '0; // see [RL20]
      end else begin
         state_reg <= state_next;
      end
   end

   // Level requests follow the synchronised pin, so a level gone before the clock
   // runs again raises nothing; the driver must hold it long enough
   always_comb begin
      for (int i = 0; i < EXT_PINS; i++) begin
         if (levelMode[i]) begin
            extReq[i] = ~extSync[i]; // see [RL5] [RL16] [RL4]
         end else begin
            extReq[i] = state_reg.extIrqFlags[i];
         end
      end
   end

   // Separate vector requests gated by enable and global flag
   assign reqPinZero = extReq[0] & state_reg.extIrqEnableMask[0] & globalIntEnable; // see [RL10] [RL11]
   assign reqPinOne = extReq[1] & state_reg.extIrqEnableMask[1] & globalIntEnable; // see [RL10] [RL11]
   assign reqGroup = state_reg.changeGroupFlags & state_reg.changeGroupCtrl
                     & {GROUPS{globalIntEnable}}; // see [RL18] [RL11]

   // Asynchronous wake paths, independent of the clock
   assign wakeLevel = |(state_reg.extIrqEnableMask & levelMode & ~extRaw); // see [RL6] [RL21]
   assign wakeChange = (|((pinChangeInputs ^ state_reg.changePrev) & changeMask
      & {{GROUP_TWO_W{state_reg.changeGroupCtrl[2]}}, 1'b0,
         {GROUP_ONE_W{state_reg.changeGroupCtrl[1]}},
         {GROUP_ZERO_W{state_reg.changeGroupCtrl[0]}}})); // see [RL7] [RL21]

   assign regRdData = state_reg.rdData;
endmodule // external_pin_interrupts

/* File: hw/pin_sync.sv */
// Two-stage synchroniser for a vector of pins.
// Assumes inputs are asynchronous to clk; ce freezes both stages.
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] pinOut
);
   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sync_state_t;

   sync_state_t state_reg;
   sync_state_t state_next;

   always_comb begin
      state_next = state_reg;
      if (ce) begin
         state_next.first = pinIn;
         state_next.second = state_reg.first;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign pinOut = state_reg.second;
endmodule // pin_sync

/* File: testbench/cpu_vector_model.sv */
// CPU vector-entry model: takes one pending request at a time, promptly or slowly.
// Assumes level requests; acks change at the falling edge and last one cycle.
`timescale 1ns/1ps
module cpu_vector_model (
   input wire logic clk,
   input wire logic autoAck,
   input wire logic slowAck,
   input wire logic reqPinZero,
   input wire logic reqPinOne,
   input wire logic [ext_irq_pkg::GROUPS-1:0] reqGroup,
   output logic ackPinZero,
   output logic ackPinOne,
   output logic [ext_irq_pkg::GROUPS-1:0] ackGroup
);
   import ext_irq_pkg::*;
   initial begin
      forever begin
         ackPinZero = 1'b0;
         ackPinOne = 1'b0;
         ackGroup = '0;
         @(negedge clk);
         if (autoAck && (reqPinZero || reqPinOne || reqGroup != '0)) begin
            if (slowAck) repeat (4) @(negedge clk);
            if (reqPinZero) ackPinZero = 1'b1;
            else if (reqPinOne) ackPinOne = 1'b1;
            else ackGroup = reqGroup & (~reqGroup + 3'h1);
            @(negedge clk);
         end
      end
   end
endmodule // cpu_vector_model

/* File: testbench/ext_irq_properties.sv */
// Port checker for external_pin_interrupts.
// Assumes only the top ports; sense and mask are tracked from register writes.
`timescale 1ns/1ps
module ext_irq_properties (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic extPinZero,
   input wire logic extPinOne,
   input wire logic globalIntEnable,
   input wire logic [7:0] regAddr,
   input wire logic ioSpace,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData,
   input wire logic ackPinZero,
   input wire logic ackPinOne,
   input wire logic reqPinZero,
   input wire logic reqPinOne,
   input wire logic [ext_irq_pkg::GROUPS-1:0] reqGroup,
   input wire logic wakeLevel
);
   import ext_irq_pkg::*;
   logic [7:0] dAddr;
   logic [7:0] senseReg;
   logic [7:0] maskReg;
   assign dAddr = !ioSpace ? regAddr : (regAddr > IO_TOP ? ADDR_NONE : regAddr + IO_OFFSET);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         senseReg <= REG_RESET;
         maskReg <= REG_RESET;
      end else if (ce && regWrite) begin
         if (dAddr == ADDR_SENSE_CTRL) senseReg <= regWrData;
         if (dAddr == ADDR_EXT_MASK) maskReg <= regWrData;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence fallZero;
      ce ##1 (ce && !regWrite && globalIntEnable && maskReg[0] && senseReg[1:0] == SENSE_FALL
         && $fell(extPinZero));
   endsequence
   sequence riseOne;
      ce ##1 (ce && !regWrite && globalIntEnable && maskReg[1] && senseReg[3:2] == SENSE_RISE
         && $rose(extPinOne));
   endsequence
   AST_FALL_ZERO: assert property (
      fallZero ##1 (ce && !ackPinZero && !regWrite && globalIntEnable)[*3] |-> reqPinZero)
      else $error("falling edge gave no request");
   AST_RISE_ONE: assert property (
      riseOne ##1 (ce && !ackPinOne && !regWrite && globalIntEnable)[*3] |-> reqPinOne)
      else $error("rising edge gave no request");
   AST_LEVEL_ZERO: assert property (
      (ce && globalIntEnable && maskReg[0] && senseReg[1:0] == SENSE_LOW && !extPinZero)[*3]
      |-> reqPinZero) else $error("level request missing");
   AST_ACK_ONE: assert property (
      (ce && $stable(extPinOne))[*4] ##0 (ackPinOne && !regWrite && senseReg[3:2] != SENSE_LOW)
      |=> !reqPinOne) else $error("vector entry left request up");
   AST_NO_GIE: assert property (
      !globalIntEnable |-> !reqPinZero && !reqPinOne && reqGroup == '0)
      else $error("request without global enable");
   AST_RD_HOLD: assert property (
      !(ce && regRead) |=> $stable(regRdData)) else $error("read data moved without read");
   AST_UNMAPPED: assert property (
      ce && regRead && dAddr == ADDR_NONE |=> regRdData == 8'h00) else $error("unmapped read");
   AST_LEVEL_FLAG: assert property (
      ce && regRead && !regWrite && dAddr == ADDR_EXT_FLAGS && senseReg[1:0] == SENSE_LOW
      |=> !regRdData[0]) else $error("flag set in level mode");
   AST_WAKE_LEVEL: assert property (
      wakeLevel |-> (!extPinZero && maskReg[0] && senseReg[1:0] == SENSE_LOW)
      || (!extPinOne && maskReg[1] && senseReg[3:2] == SENSE_LOW)) else $error("stray wake");
endmodule // ext_irq_properties
bind external_pin_interrupts ext_irq_properties PROPS (.*);

/* File: testbench/external_pin_interrupts_tb_top.sv */
// Directed testbench for external_pin_interrupts.
// Assumes the vector model on the CPU side; pins are driven here.
`timescale 1ns/1ps
module external_pin_interrupts_tb_top;
   import ext_irq_pkg::*;
   logic clk, rstn, ce, extPinZero, extPinOne, globalIntEnable, ioSpace, regWrite, regRead;
   logic [CHANGE_PINS-1:0] pinChangeInputs;
   logic [7:0] regAddr, regWrData, regRdData;
   logic ackPinZero, ackPinOne, reqPinZero, reqPinOne, wakeLevel, wakeChange, autoAck, slowAck;
   logic [GROUPS-1:0] ackGroup, reqGroup;
   logic [7:0] addrs [8] = '{8'h3b, 8'h3c, 8'h3d, 8'h68, 8'h69, 8'h6b, 8'h6c, 8'h6d};
   logic [7:0] used [8] = '{8'h00, 8'h00, 8'h03, 8'h07, 8'h0f, 8'hff, 8'h7f, 8'hff};
   logic [23:0] pins [3] = '{24'h000001, 24'h004000, 24'h800000};
   int miscompares = 0;
   int check_count = 0;
   external_pin_interrupts DUT (.*);
   cpu_vector_model PARTNER (.*);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic check(input string w, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      {ioSpace, regAddr, regWrData, regWrite} = {io, a, d, 1'b1};
      @(negedge clk);
      regWrite = 1'b0;
   endtask
   task automatic rd(input logic io, input logic [7:0] a, input logic [7:0] e, input string w);
      @(negedge clk);
      {ioSpace, regAddr, regRead} = {io, a, 1'b1};
      @(negedge clk);
      regRead = 1'b0;
      check(w, e, regRdData);
   endtask
   task automatic regs_test();
      foreach (addrs[i]) begin
         rd(0, addrs[i], 8'h00, "reset");
         wr(0, addrs[i], 8'hff);
         rd(0, addrs[i], used[i], "bits");
         wr(0, addrs[i], 8'h00);
      end
      wr(1, 8'h49, 8'hff);
      rd(0, ADDR_SENSE_CTRL, 8'h00, "io top");
      wr(1, 8'h1d, 8'h02);
      rd(0, ADDR_EXT_MASK, 8'h02, "io mask");
      rd(0, ADDR_NONE, 8'h00, "unmapped");
   endtask
   task automatic sense_test();
      for (int m = 1; m < 4; m++) begin
         wr(0, ADDR_SENSE_CTRL, 8'(((m % 3 + 1) << 2) | m));
         wr(0, ADDR_EXT_FLAGS, 8'h03);
         {extPinZero, extPinOne} = 2'b00;
         cyc(4);
         rd(0, ADDR_EXT_FLAGS, {6'h0, m % 3 + 1 < 3, m < 3}, "fall");
         wr(1, 8'h1c, 8'h03);
         rd(0, ADDR_EXT_FLAGS, 8'h00, "w1c");
         {extPinZero, extPinOne} = 2'b11;
         cyc(4);
         rd(0, ADDR_EXT_FLAGS, {6'h0, m % 3 != 1, m != 2}, "rise");
         wr(0, ADDR_EXT_FLAGS, 8'h03);
      end
   endtask
   task automatic level_test();
      wr(0, ADDR_SENSE_CTRL, 8'h00);
      wr(0, ADDR_EXT_MASK, 8'h01);
      extPinZero = 1'b0;
      cyc(4);
      check("gated", 8'h00, reqPinZero);
      {globalIntEnable, autoAck} = 2'b11;
      cyc(10);
      check("level req", 8'h01, reqPinZero);
      rd(0, ADDR_EXT_FLAGS, 8'h00, "level flag");
      ce = 1'b0;
      #1 check("wake", 8'h01, wakeLevel);
      cyc(1);
      extPinZero = 1'b1;
      cyc(1);
      ce = 1'b1;
      cyc(4);
      check("vanished", 8'h00, reqPinZero);
   endtask
   task automatic ack_test();
      wr(0, ADDR_SENSE_CTRL, 8'h0e);
      wr(0, ADDR_EXT_MASK, 8'h03);
      {autoAck, slowAck} = 2'b00;
      wr(0, ADDR_EXT_FLAGS, 8'h03);
      extPinZero = 1'b0;
      cyc(5);
      check("own vector", 8'h01, {reqPinOne, reqPinZero});
      {autoAck, slowAck, extPinZero, extPinOne} = 4'b1110;
      cyc(2);
      extPinOne = 1'b1;
      cyc(20);
      rd(0, ADDR_EXT_FLAGS, 8'h00, "entry");
   endtask
   task automatic change_test();
      wr(0, ADDR_MASK_ZERO, 8'h01);
      wr(0, ADDR_MASK_ONE, 8'h40);
      wr(0, ADDR_MASK_TWO, 8'h80);
      pinChangeInputs = 24'h008002;
      cyc(4);
      rd(0, ADDR_CHANGE_FLAGS, 8'h00, "masked");
      for (int g = 0; g < 3; g++) begin
         pinChangeInputs ^= pins[g];
         cyc(4);
         rd(0, ADDR_CHANGE_FLAGS, 8'(1 << g), "group");
         wr(1, 8'h1b, 8'h07);
      end
      {autoAck, slowAck} = 2'b00;
      wr(0, ADDR_GROUP_CTRL, 8'h04);
      ce = 1'b0;
      pinChangeInputs ^= pins[2];
      #1 check("wake change", 8'h01, wakeChange);
      cyc(1);
      ce = 1'b1;
      cyc(4);
      check("group req", 8'h04, reqGroup);
      autoAck = 1'b1;
      cyc(3);
      check("group entry", 8'h00, reqGroup);
   endtask
   task automatic final_report();
      if (miscompares == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      {rstn, ce, extPinZero, extPinOne, globalIntEnable, autoAck, slowAck} = 7'b0111000;
      {ioSpace, regWrite, regRead, regAddr, regWrData, pinChangeInputs} = '0;
      cyc(3);
      rstn = 1'b1;
      regs_test();
      sense_test();
      level_test();
      ack_test();
      change_test();
      final_report();
   end
   initial begin
      #50000;
      miscompares++;
      final_report();
   end
endmodule // external_pin_interrupts_tb_top
